/* File: design/pls_pkg.sv */
// Shared constants and types for the link status 2 and power management register bank
package pls_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address of each register is four times its index
    localparam int unsigned ADDR_W = 12;
    localparam logic [ADDR_W-1:0] IDX_LINK_STATUS_TWO = 12'h072;
    localparam logic [ADDR_W-1:0] IDX_SLOT_CAPABILITIES_TWO = 12'h074;
    localparam logic [ADDR_W-1:0] IDX_SLOT_CONTROL_TWO = 12'h078;
    localparam logic [ADDR_W-1:0] IDX_SLOT_STATUS_TWO = 12'h07a;
    localparam logic [ADDR_W-1:0] IDX_POWER_MGMT_CAPABILITY = 12'h0c0;
    localparam logic [ADDR_W-1:0] IDX_LOCK_CONTROL = 12'h0f0;
    localparam logic [ADDR_W-1:0] IDX_WAKE_FWD_COUNT = 12'h0f1;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and fixed or reset values
    localparam int unsigned DEEMPH_BIT = 0;
    localparam logic DEEMPH_RST = 1'b0;
    localparam int unsigned CAP_ID_LSB = 0;
    localparam logic [7:0] CAP_ID_VAL = 8'h01;
    localparam int unsigned NEXT_PTR_LSB = 8;
    localparam logic [7:0] NEXT_PTR_RST = 8'hd0;
    localparam int unsigned PM_VERSION_LSB = 16;
    localparam logic [2:0] PM_VERSION_VAL = 3'h3;
    localparam int unsigned WAKE_CLK_BIT = 19;
    localparam int unsigned PM_CAP_RSVD_BIT = 20;
    localparam int unsigned INIT_FLAG_BIT = 21;
    localparam logic INIT_FLAG_RST = 1'b0;
    localparam int unsigned AUX_CUR_LSB = 22;
    localparam logic [2:0] AUX_CUR_VAL = 3'h0;
    localparam int unsigned LIGHT_SLEEP_BIT = 25;
    localparam int unsigned DEEP_SLEEP_BIT = 26;
    localparam int unsigned WAKE_SUP_LSB = 27;
    localparam logic [4:0] WAKE_SUP_RST = 5'h19;
    // Cold state never forwards, whatever is advertised
    localparam logic [4:0] WAKE_COLD_MASK = 5'h10;
    localparam int unsigned LOCK_EN_BIT = 0;
    localparam logic LOCK_EN_RST = 1'b0;
    localparam int unsigned WAKE_CNT_W = 16;
    localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Port power states, one code per bit of the wake support field
    typedef enum logic [2:0] {
        PLS_D0 = 3'b000,
        PLS_D1 = 3'b001,
        PLS_D2 = 3'b010,
        PLS_D3_HOT = 3'b011,
        PLS_D3_COLD = 3'b100
    } pls_pstate_t;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] idx);
        return {idx[ADDR_W-3:0], 2'b00};
    endfunction

endpackage

/* File: design/pls_apb_decode.sv */
// Address decoder for the register bank
`timescale 1ns/1ns
module pls_apb_decode (
    input wire logic [pls_pkg::ADDR_W-1:0] paddr_i,
    output logic hit_lsts2_o,
    output logic hit_scap2_o,
    output logic hit_sctl2_o,
    output logic hit_ssts2_o,
    output logic hit_pm_cap_o,
    output logic hit_lock_o,
    output logic hit_cnt_o,
    output logic hit_any_o
);
    import pls_pkg::*;

    // Exact word match; misaligned addresses hit nothing
    function automatic logic match(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
        return a == byte_addr(idx);
    endfunction

    assign hit_lsts2_o = match(paddr_i, IDX_LINK_STATUS_TWO);
    assign hit_scap2_o = match(paddr_i, IDX_SLOT_CAPABILITIES_TWO);
    assign hit_sctl2_o = match(paddr_i, IDX_SLOT_CONTROL_TWO);
    assign hit_ssts2_o = match(paddr_i, IDX_SLOT_STATUS_TWO);
    assign hit_pm_cap_o = match(paddr_i, IDX_POWER_MGMT_CAPABILITY);
    assign hit_lock_o = match(paddr_i, IDX_LOCK_CONTROL);
    assign hit_cnt_o = match(paddr_i, IDX_WAKE_FWD_COUNT);
    assign hit_any_o = hit_lsts2_o | hit_scap2_o | hit_sctl2_o | hit_ssts2_o
        | hit_pm_cap_o | hit_lock_o | hit_cnt_o;

endmodule

/* File: design/pls_wake_fwd.sv */
// Wake-event message forwarding gate driven by the port power state
`timescale 1ns/1ns
module pls_wake_fwd (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire pls_pkg::pls_pstate_t power_state_i,
    input wire logic wake_msg_i,
    output logic wake_fwd_o
);
    import pls_pkg::*;

    logic fwd_q;
    logic fwd_d;
    logic [4:0] fwd_mask;
    logic state_ok;

    // The advertised copy never reaches this gate
    // [RL14] [RL15] default set, cold masked
    assign fwd_mask = WAKE_SUP_RST & ~WAKE_COLD_MASK;
    assign state_ok = (power_state_i <= PLS_D3_COLD) ? fwd_mask[power_state_i] : 1'b0;
    assign fwd_d = wake_msg_i & state_ok;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fwd_q <= 1'b0;
        end else begin
            fwd_q <= fwd_d;
        end
    end

    assign wake_fwd_o = fwd_q;

endmodule

/* File: design/pls_regs.sv */
// APB register bank: link status 2, slot 2 registers and power management capability header
//
// What this block does
// [RL1] At 5.0 Gbps, bit 0 of link status two shows the active de-emphasis.
// [RL2] Software ignores the de-emphasis bit at the lower signalling rate.
// [RL3] Link status two bits 15 to 1 read as zero.
// [RL4] Slot capabilities two is all reserved and reads zero.
// [RL5] Slot control two and slot status two are reserved, read zero.
// [RL6] Capability identifier byte reads constant 0x1.
// [RL7] Next capability pointer in bits 15:8, writable only when locked writes allowed.
// [RL8] Power management version field reads constant 0x3.
// [RL9] Wake event clock flag always reads zero.
// [RL10] Device specific init flag resets to zero, changes only by locked write.
// [RL11] Auxiliary current field always reads zero.
// [RL12] Light and deep sleep support bits both read zero.
// [RL13] Wake state support field resets to 0b11001.
// [RL14] Wake-event messages are never forwarded in the cold unpowered state.
// [RL15] Writing wake state support changes only the advertised value.
// [RL16] Power management capability bit 20 is reserved and reads zero.
// [RL17] Writes to read-only or reserved bits are ignored.
`timescale 1ns/1ns
module pls_regs #(
    parameter logic [7:0] NEXT_PTR_RST_P = pls_pkg::NEXT_PTR_RST
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [pls_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic link_speed_5g_i,
    input wire logic deemph_level_i,
    input wire pls_pkg::pls_pstate_t power_state_i,
    input wire logic wake_msg_i,
    output logic wake_fwd_o,
    output logic [4:0] wake_state_support_o
);
    import pls_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic hit_lsts2;
    logic hit_scap2;
    logic hit_sctl2;
    logic hit_ssts2;
    logic hit_pm_cap;
    logic hit_lock;
    logic hit_cnt;
    logic hit_any;
    logic setup_ph;
    logic wr_acc;
    logic lock_wr;
    logic deemph_q;
    logic [7:0] next_ptr_q;
    logic init_flag_q;
    logic [4:0] wake_adv_q;
    logic lock_en_q;
    logic [WAKE_CNT_W-1:0] wake_cnt_q;
    logic [WAKE_CNT_W-1:0] wake_cnt_d;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [31:0] lsts2_word;
    logic [31:0] pm_cap_word;
    logic [31:0] lock_word;
    logic [31:0] cnt_word;
    logic [31:0] rd_word;
    logic cnt_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and bus phases
    pls_apb_decode u_decode (
        .paddr_i(paddr_i),
        .hit_lsts2_o(hit_lsts2),
        .hit_scap2_o(hit_scap2),
        .hit_sctl2_o(hit_sctl2),
        .hit_ssts2_o(hit_ssts2),
        .hit_pm_cap_o(hit_pm_cap),
        .hit_lock_o(hit_lock),
        .hit_cnt_o(hit_cnt),
        .hit_any_o(hit_any)
    );

    assign setup_ph = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pwrite_i;
    // [RL7] locked write gate
    assign lock_wr = wr_acc & hit_pm_cap & lock_en_q;

    ////////////////////////////////////////////////////////////////////////////
    // De-emphasis report
    // [RL1] follow the PHY at 5.0 Gbps
    // At the low rate the bit holds its last value; software must not trust it
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            deemph_q <= DEEMPH_RST;
        end else if (link_speed_5g_i) begin
            deemph_q <= deemph_level_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Locked-write fields of the capability header
    // [RL7] next pointer update
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            next_ptr_q <= NEXT_PTR_RST_P;
        end else if (lock_wr && pstrb_i[1]) begin
            next_ptr_q <= pwdata_i[NEXT_PTR_LSB +: 8];
        end
    end

    // [RL10] init flag reset and locked update
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_flag_q <= INIT_FLAG_RST;
        end else if (lock_wr && pstrb_i[2]) begin
            init_flag_q <= pwdata_i[INIT_FLAG_BIT];
        end
    end

    // [RL13] advertised wake states
    // [RL15] advertised copy only
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_adv_q <= WAKE_SUP_RST;
        end else if (lock_wr && pstrb_i[3]) begin
            wake_adv_q <= pwdata_i[WAKE_SUP_LSB +: 5];
        end
    end

    assign wake_state_support_o = wake_adv_q;

    ////////////////////////////////////////////////////////////////////////////
    // Lock control register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_en_q <= LOCK_EN_RST;
        end else if (wr_acc && hit_lock && pstrb_i[0]) begin
            lock_en_q <= pwdata_i[LOCK_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake forwarding and its event counter
    // [RL14] cold state gate
    pls_wake_fwd u_wake (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .power_state_i(power_state_i),
        .wake_msg_i(wake_msg_i),
        .wake_fwd_o(wake_fwd_o)
    );

    // A forward in the clearing cycle is counted, so no event is lost
    assign cnt_clr = wr_acc & hit_cnt & pstrb_i[0];
    assign wake_cnt_d = (cnt_clr ? WAKE_CNT_RST : wake_cnt_q)
        + {{(WAKE_CNT_W-1){1'b0}}, wake_fwd_o};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_cnt_q <= WAKE_CNT_RST;
        end else begin
            wake_cnt_q <= wake_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read words
    // [RL3] only bit 0 is live
    assign lsts2_word = {31'h0000_0000, deemph_q};

    // [RL6] [RL8] [RL9] [RL11] [RL12] [RL16] fixed header fields
    // [RL17] constants, no write path
    assign pm_cap_word = {wake_adv_q, 1'b0, 1'b0, AUX_CUR_VAL, init_flag_q, 1'b0, 1'b0,
        PM_VERSION_VAL, next_ptr_q, CAP_ID_VAL};
    assign lock_word = {31'h0000_0000, lock_en_q};
    assign cnt_word = {{(32-WAKE_CNT_W){1'b0}}, wake_cnt_q};

    // [RL4] [RL5] reserved slot registers fall through to zero
    assign rd_word = hit_lsts2 ? lsts2_word :
        hit_pm_cap ? pm_cap_word :
        hit_lock ? lock_word :
        hit_cnt ? cnt_word : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: read data and error latched in the setup cycle, no wait states
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            prdata_q <= pwrite_i ? 32'h0000_0000 : rd_word;
            pslverr_q <= ~hit_any;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = psel_i & penable_i;
    assign pslverr_o = pslverr_q & psel_i & penable_i;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_rd_setup(hit);
        psel_i && !penable_i && !pwrite_i && hit;
    endsequence

    sequence s_rd_access;
        psel_i && penable_i && pready_o;
    endsequence

    sequence s_lock_wr(strb_bit);
        psel_i && penable_i && pwrite_i && hit_pm_cap && lock_en_q && strb_bit;
    endsequence

    sequence s_open_wr;
        psel_i && penable_i && pwrite_i && hit_pm_cap && !lock_en_q;
    endsequence

    chk_deemph_follow: assert property ( // [RL1]
        link_speed_5g_i |=> deemph_q == $past(deemph_level_i)
    ) else $error("de-emphasis bit did not follow the PHY at 5.0 Gbps");

    chk_deemph_readback: assert property ( // [RL1]
        s_rd_setup(hit_lsts2) ##1 s_rd_access |-> prdata_o[0] == $past(deemph_q)
    ) else $error("link status two bit 0 does not show de-emphasis");

    chk_lsts2_upper: assert property ( // [RL3]
        s_rd_setup(hit_lsts2) |=> prdata_o[31:1] == 31'h0000_0000
    ) else $error("link status two upper bits not zero");

    chk_scap2_zero: assert property ( // [RL4]
        s_rd_setup(hit_scap2) |=> prdata_o == 32'h0000_0000 && !pslverr_o
    ) else $error("slot capabilities two not zero");

    chk_slot_ctl_sts: assert property ( // [RL5]
        s_rd_setup(hit_sctl2 || hit_ssts2) |=> prdata_o == 32'h0000_0000
    ) else $error("slot control or status two not zero");

    chk_cap_id_fixed: assert property ( // [RL6]
        s_rd_setup(hit_pm_cap) |=> prdata_o[7:0] == 8'h01
    ) else $error("capability identifier not 0x1");

    chk_next_ptr_locked: assert property ( // [RL7]
        s_lock_wr(pstrb_i[1]) |=> next_ptr_q == $past(pwdata_i[15:8])
    ) else $error("locked write did not load next pointer");

    chk_locked_open: assert property ( // [RL7]
        s_open_wr |=> $stable(next_ptr_q) && $stable(init_flag_q) && $stable(wake_adv_q)
    ) else $error("unlocked write changed a locked field");

    chk_version_fixed: assert property ( // [RL8]
        s_rd_setup(hit_pm_cap) |=> prdata_o[18:16] == 3'h3
    ) else $error("power management version not 0x3");

    chk_fixed_zeros: assert property ( // [RL9]
        s_rd_setup(hit_pm_cap) |=> prdata_o[20:19] == 2'b00 && prdata_o[26:22] == 5'h00
    ) else $error("fixed zero fields of the capability header set");

    chk_init_locked: assert property ( // [RL10]
        s_lock_wr(pstrb_i[2]) |=> init_flag_q == $past(pwdata_i[21])
    ) else $error("locked write did not load init flag");

    chk_wake_adv_rd: assert property ( // [RL13]
        s_rd_setup(hit_pm_cap) |=> prdata_o[31:27] == $past(wake_adv_q)
    ) else $error("wake state support readback wrong");

    chk_cold_no_fwd: assert property ( // [RL14]
        wake_msg_i && power_state_i == PLS_D3_COLD |=> !wake_fwd_o
    ) else $error("wake message forwarded in cold state");

    chk_fwd_default: assert property ( // [RL15]
        wake_msg_i && (power_state_i == PLS_D0 || power_state_i == PLS_D3_HOT)
            |=> wake_fwd_o
    ) else $error("wake message not forwarded in a default state");

    chk_fwd_not_adv: assert property ( // [RL15]
        (power_state_i == PLS_D1 || power_state_i == PLS_D2) |=> !wake_fwd_o
    ) else $error("forwarding followed the advertised copy");

    chk_ro_write: assert property ( // [RL17]
        psel_i && penable_i && pwrite_i && hit_lsts2 && !link_speed_5g_i
            |=> $stable(deemph_q)
    ) else $error("write to link status two changed it");

    chk_apb_answer: assert property (
        psel_i && !penable_i ##1 psel_i && penable_i |-> pready_o
            && pslverr_o == $past(!hit_any)
    ) else $error("access phase answer wrong");

    chk_cnt_event: assert property (
        wake_fwd_o && !cnt_clr |=> wake_cnt_q == $past(wake_cnt_q) + 16'h0001
    ) else $error("forwarded wake event not counted");

    chk_lock_ctl_load: assert property ( // [RL7]
        wr_acc && hit_lock && pstrb_i[0] |=> lock_en_q == $past(pwdata_i[0])
    ) else $error("lock control did not load");

    chk_wake_adv_locked: assert property ( // [RL15]
        s_lock_wr(pstrb_i[3]) |=> wake_adv_q == $past(pwdata_i[31:27])
    ) else $error("locked write did not load advertised wake states");

    chk_next_ptr_rd: assert property ( // [RL7]
        s_rd_setup(hit_pm_cap) |=> prdata_o[15:8] == $past(next_ptr_q)
    ) else $error("next pointer readback wrong");

    chk_init_flag_rd: assert property ( // [RL10]
        s_rd_setup(hit_pm_cap) |=> prdata_o[21] == $past(init_flag_q)
    ) else $error("init flag readback wrong");

    chk_aux_zero: assert property ( // [RL11]
        s_rd_setup(hit_pm_cap) |=> prdata_o[24:22] == 3'h0
    ) else $error("auxiliary current field not zero");

    chk_sleep_zero: assert property ( // [RL12]
        s_rd_setup(hit_pm_cap) |=> prdata_o[26:25] == 2'b00
    ) else $error("sleep support bits not zero");

    chk_rsvd_bit20: assert property ( // [RL16]
        s_rd_setup(hit_pm_cap) |=> !prdata_o[20]
    ) else $error("capability bit 20 not zero");

    chk_deemph_hold: assert property ( // [RL1]
        !link_speed_5g_i |=> $stable(deemph_q)
    ) else $error("de-emphasis bit changed at the low rate");

    chk_unmapped_err: assert property (
        s_rd_setup(!hit_any) ##1 s_rd_access |-> pslverr_o && prdata_o == 32'h0000_0000
    ) else $error("unmapped read not refused");

    chk_write_rdata: assert property (
        psel_i && !penable_i && pwrite_i |=> prdata_o == 32'h0000_0000
    ) else $error("write returned read data");

    chk_cnt_clear: assert property (
        cnt_clr && !wake_fwd_o |=> wake_cnt_q == WAKE_CNT_RST
    ) else $error("wake count did not clear");

    chk_fwd_pulse: assert property ( // [RL15]
        wake_fwd_o |-> $past(wake_msg_i)
    ) else $error("forward without a wake message");

endmodule

/* File: test/pls_regs_tb.sv */
// Self-checking testbench for the link status 2 and power management register bank
`timescale 1ns/1ns
module pls_regs_tb;
    import pls_pkg::*;

    localparam logic [11:0] A_LS = IDX_LINK_STATUS_TWO << 2;
    localparam logic [11:0] A_SC = IDX_SLOT_CAPABILITIES_TWO << 2;
    localparam logic [11:0] A_SCT = IDX_SLOT_CONTROL_TWO << 2;
    localparam logic [11:0] A_SS = IDX_SLOT_STATUS_TWO << 2;
    localparam logic [11:0] A_PM = IDX_POWER_MGMT_CAPABILITY << 2;
    localparam logic [11:0] A_LK = IDX_LOCK_CONTROL << 2;
    localparam logic [11:0] A_CNT = IDX_WAKE_FWD_COUNT << 2;

    logic mclk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic speed5g;
    logic deemph;
    pls_pstate_t pstate;
    logic wake_msg;
    logic wake_fwd;
    logic [4:0] wake_sup;
    logic [31:0] rd;
    logic err;
    int miscompares;
    int check_count;

    pls_regs DUT (.mclk_i(mclk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .link_speed_5g_i(speed5g), .deemph_level_i(deemph), .power_state_i(pstate),
        .wake_msg_i(wake_msg), .wake_fwd_o(wake_fwd), .wake_state_support_o(wake_sup));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Expected capability word built field by field
    function automatic logic [31:0] pm(input logic [7:0] p, input logic f, input logic [4:0] w);
        return {w, 5'h00, f, 1'h0, 1'h0, 3'h3, p, 8'h01};
    endfunction

    // Idle cycle before each setup, so no signal is assigned twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // Wait for ready; only the watchdog ends a hung transfer
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk(rd, exp, "read data");
        chk({31'h0, err}, 32'h0, "read error");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
        chk({31'h0, err}, 32'h0, "write error");
    endtask

    task automatic wake(input pls_pstate_t s, input logic exp);
        @(posedge mclk);
        wake_msg <= 1'b1;
        pstate <= s;
        @(posedge mclk);
        wake_msg <= 1'b0;
        // Look mid-cycle, while the one-cycle forward pulse stands
        @(negedge mclk);
        chk({31'h0, wake_fwd}, {31'h0, exp}, "wake forward");
    endtask

    task automatic do_reset;
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [11:0] ro_a [5];
        logic [31:0] ro_e [5];
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        speed5g = 1'b0;
        deemph = 1'b0;
        pstate = PLS_D0;
        wake_msg = 1'b0;
        miscompares = 0;
        check_count = 0;
        do_reset();
        rd_chk(A_LS, 32'h0000_0000);
        rd_chk(A_SC, 32'h0000_0000);
        rd_chk(A_SCT, 32'h0000_0000);
        rd_chk(A_SS, 32'h0000_0000);
        rd_chk(A_PM, pm(8'hd0, 1'b0, 5'h19));
        chk({27'h0, wake_sup}, 32'h0000_0019, "advertised wake");
        $display("test reset values done");

        @(posedge mclk);
        speed5g <= 1'b1;
        deemph <= 1'b1;
        rd_chk(A_LS, 32'h0000_0001);
        @(posedge mclk);
        speed5g <= 1'b0;
        deemph <= 1'b0;
        // Low rate value is undefined; the design holds the last one
        rd_chk(A_LS, 32'h0000_0001);
        @(posedge mclk);
        speed5g <= 1'b1;
        rd_chk(A_LS, 32'h0000_0000);
        $display("test de-emphasis done");

        ro_a = '{A_LS, A_SC, A_SCT, A_SS, A_PM};
        ro_e = '{32'h0, 32'h0, 32'h0, 32'h0, pm(8'hd0, 1'b0, 5'h19)};
        for (int i = 0; i < 5; i++) begin
            wr(ro_a[i], 32'hffff_ffff, 4'hf);
            rd_chk(ro_a[i], ro_e[i]);
        end
        $display("test read-only writes done");

        wr(A_LK, 32'h0000_0001, 4'h1);
        rd_chk(A_LK, 32'h0000_0001);
        wr(A_PM, 32'hffff_ffff, 4'h2);
        rd_chk(A_PM, pm(8'hff, 1'b0, 5'h19));
        wr(A_PM, 32'hffff_ffff, 4'hc);
        rd_chk(A_PM, pm(8'hff, 1'b1, 5'h1f));
        chk({27'h0, wake_sup}, 32'h0000_001f, "advertised wake");
        wr(A_PM, 32'h0000_0000, 4'hf);
        rd_chk(A_PM, pm(8'h00, 1'b0, 5'h00));
        wr(A_LK, 32'h0000_0000, 4'h1);
        wr(A_PM, 32'hffff_ffff, 4'hf);
        rd_chk(A_PM, pm(8'h00, 1'b0, 5'h00));
        $display("test locked writes done");

        // Advertised field is now zero; forwarding must not follow it
        for (int i = 0; i < 5; i++) begin
            wake(pls_pstate_t'(i[2:0]), (i == 0) || (i == 3));
        end
        rd_chk(A_CNT, 32'h0000_0002);
        wr(A_CNT, 32'h0000_0000, 4'h1);
        rd_chk(A_CNT, 32'h0000_0000);
        $display("test wake forwarding done");

        apb(1'b0, 12'h004, 32'h0000_0000, 4'h0);
        chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
        apb(1'b0, A_LS + 12'h001, 32'h0000_0000, 4'h0);
        chk({rd[30:0], err}, 32'h0000_0001, "misaligned read");
        apb(1'b1, 12'h004, 32'hffff_ffff, 4'hf);
        chk({31'h0, err}, 32'h0000_0001, "unmapped write");
        $display("test unmapped done");

        wr(A_LK, 32'h0000_0001, 4'h1);
        wr(A_PM, 32'hffff_ffff, 4'hf);
        wake(PLS_D0, 1'b1);
        // Cold bit is advertised now, yet nothing may be forwarded there
        wake(PLS_D3_COLD, 1'b0);
        do_reset();
        rd_chk(A_PM, pm(8'hd0, 1'b0, 5'h19));
        chk({27'h0, wake_sup}, 32'h0000_0019, "advertised wake");
        rd_chk(A_LK, 32'h0000_0000);
        rd_chk(A_CNT, 32'h0000_0000);
        $display("test second reset done");
        test_done();
    end

    initial begin
        repeat (3000) @(posedge mclk);
        miscompares++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done();
    end
endmodule
